// file: bench/sawb_peer.sv
// Purpose: remote serial node on the async line
// Assumes: bit time of BIT clocks, line idles high
// Notes: decodes tx frames, breaks reported as {1,low bit count}
`timescale 1ns/1ps
`default_nettype none
module sawb_peer #(
  parameter int BIT = 32
) (
  // clock
  input wire logic clk,
  // serial lines
  output logic rxLine,
  input wire logic txLine,
  input wire logic listen,
  // decoded frames
  output logic frmValid,
  output logic [8:0] frmData
);
  initial begin
    rxLine = 1'b1;
    frmValid = 1'b0;
    frmData = '0;
  end
  // ----------------------------------------
  // sender: start, nb bits lsb first, one stop
  // ----------------------------------------
  // wide enough that a twelve-bit break never indexes past the word
  task automatic sendWord(input logic [15:0] w, input int nb);
    rxLine <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      rxLine <= w[i];
      repeat (BIT) @(posedge clk);
    end
    rxLine <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  // ----------------------------------------
  // receiver: mid-bit sampling
  // ----------------------------------------
  initial begin
    logic [7:0] d;
    int n;
    forever begin
      @(negedge txLine);
      if (listen) begin
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT) @(posedge clk);
          d[i] = txLine;
        end
        repeat (BIT) @(posedge clk);
        if (txLine === 1'b1) begin
          frmData <= {1'b0, d};
        end else begin
          // low stop slot: keep counting low bits, bounded
          n = 10;
          repeat (BIT) @(posedge clk);
          while (txLine === 1'b0 && n < 30) begin
            n++;
            repeat (BIT) @(posedge clk);
          end
          frmData <= {1'b1, 8'(n)};
        end
        frmValid <= 1'b1;
        @(posedge clk);
        frmValid <= 1'b0;
      end
    end
  end
endmodule // sawb_peer
`default_nettype wire

// file: bench/sawb_tb_top.sv
// Purpose: self-checking bench for the serial address/wake/break port
// Assumes: zero wait-state slave, bit time 32 clocks (divisor 1, high speed)
// Notes: reads and tx frames checked from expectation queues
`timescale 1ns/1ps
`default_nettype none
module sawb_tb_top;
  import sawb_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sleepMode = 1'b0, listen = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, rdPh = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = '0, hwdata = '0, x = 32'hdab321a4;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, rxIrq, txFlag, txPinOut, txPinOe, rxPinOut, rxPinOe;
  wire logic peerLine, frmValid, txWire, rxWire;
  wire logic [8:0] frmData;
  logic [63:0] expRd[$];
  logic [8:0] expFrm[$];
  int errCount = 0, checkCount = 0, cycles = 0;
  // open pins: pull-up on clock/tx, peer on data when released
  assign txWire = txPinOe ? txPinOut : 1'b1;
  assign rxWire = rxPinOe ? rxPinOut : peerLine;
  sawb_top dut_u (.clk(clk), .rst(rst), .sleepMode(sleepMode), .rxIrq(rxIrq),
    .txFlag(txFlag), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .txPinOut(txPinOut), .txPinOe(txPinOe),
    .rxPin(rxWire), .rxPinOut(rxPinOut), .rxPinOe(rxPinOe));
  sawb_peer #(.BIT(32)) peer (.clk(clk), .rxLine(peerLine), .txLine(txWire),
    .listen(listen), .frmValid(frmValid), .frmData(frmData));
  initial begin
    forever #4 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x[7:0];
  endfunction
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
    checkCount++;
    if (s !== e) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic cmpRd(input logic [63:0] e, input logic [31:0] s);
    cmp("readData", e[31:0], s & e[63:32]);
  endtask
  task automatic cmpFrm(input logic [8:0] e, input logic [8:0] s);
    cmp("txFrame", {23'h0, e}, {23'h0, s});
  endtask
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    logic [63:0] e;
    logic [8:0] f;
    cycles++;
    if (rdPh && hreadyout === 1'b1) begin
      e = expRd.pop_front();
      cmpRd(e, hrdata);
    end
    if (hreadyout === 1'b1) rdPh <= hsel && htrans[1] && !hwrite;
    if (frmValid === 1'b1) begin
      f = expFrm.pop_front();
      cmpFrm(f, frmData);
    end
    if (cycles == 20000) begin
      errCount++;
      giveVerdict();
    end
  end
  // ----------------------------------------
  // bus master
  // ----------------------------------------
  task automatic busOp(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {27'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    busOp(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] v);
    expRd.push_back({m, v});
    busOp(1'b0, a, 8'h00);
  endtask
  task automatic waitFrm();
    while (expFrm.size() != 0) @(posedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [7:0] d, sd;
    logic seen;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_RXSC, 32'hffff_ffff, 32'h0);
    rd(OFS_IRQ, 32'hffff_ffff, 32'h0);
    wr(OFS_DIVL, 8'h01);
    wr(OFS_TXSC, 8'h24);
    wr(OFS_RXSC, 8'h80);
    d = rnd();
    expFrm.push_back({1'b0, d});
    wr(OFS_TXBUF, d);
    waitFrm();
    // break then sync byte; dummy value must not show
    wr(OFS_TXSC, 8'h2c);
    expFrm.push_back(9'h10d);
    expFrm.push_back(9'h055);
    wr(OFS_TXBUF, rnd() | 8'h01);
    @(posedge clk);
    cmp("txFlag", 32'h0, {31'h0, txFlag});
    for (int i = 0; i < 100 && txFlag !== 1'b1; i++) @(posedge clk);
    cmp("txFlag", 32'h1, {31'h0, txFlag});
    wr(OFS_TXBUF, 8'h55);
    waitFrm();
    rd(OFS_TXSC, 32'h08, 32'h0);
    // nine-bit address filter
    wr(OFS_RXSC, 8'hd8);
    wr(OFS_IRQ, 8'h03);
    peer.sendWord({1'b0, rnd()}, 9);
    repeat (8) @(posedge clk);
    rd(OFS_IRQ, 32'h04, 32'h0);
    d = rnd();
    peer.sendWord({1'b1, d}, 9);
    repeat (8) @(posedge clk);
    cmp("rxIrq", 32'h1, {31'h0, rxIrq});
    rd(OFS_RXSC, 32'h01, 32'h1);
    rd(OFS_RXBUF, 32'hffff_ffff, {24'h0, d});
    wr(OFS_RXSC, 8'hd0);
    wr(OFS_IRQ, 8'h02);
    d = rnd();
    peer.sendWord({1'b0, d}, 9);
    repeat (8) @(posedge clk);
    cmp("rxIrq", 32'h0, {31'h0, rxIrq});
    rd(OFS_IRQ, 32'h04, 32'h4);
    rd(OFS_RXBUF, 32'hff, {24'h0, d});
    // wake on break while asleep
    wr(OFS_RXSC, 8'h90);
    wr(OFS_IRQ, 8'h03);
    rd(OFS_BAUD, 32'h40, 32'h40);
    wr(OFS_BAUD, 8'h02);
    sleepMode <= 1'b1;
    fork
      peer.sendWord(9'h000, 12);
      begin
        repeat (64) @(posedge clk);
        cmp("rxIrq", 32'h1, {31'h0, rxIrq});
        rd(OFS_BAUD, 32'h02, 32'h2);
      end
    join
    rd(OFS_BAUD, 32'h02, 32'h0);
    rd(OFS_RXSC, 32'h06, 32'h0);
    sleepMode <= 1'b0;
    rd(OFS_RXBUF, 32'hff, {24'h0, d});
    rd(OFS_IRQ, 32'h04, 32'h0);
    d = rnd();
    peer.sendWord({1'b0, d}, 8);
    repeat (8) @(posedge clk);
    rd(OFS_RXBUF, 32'hff, {24'h0, d});
    // break at two-thirds of the peer rate lands as a clean zero word
    wr(OFS_DIVL, 8'h02);
    peer.sendWord(16'h0000, 12);
    repeat (24) @(posedge clk);
    rd(OFS_RXSC, 32'h06, 32'h0);
    rd(OFS_RXBUF, 32'hff, 32'h0);
    // sync master, clock idles at polarity
    listen <= 1'b0;
    wr(OFS_RXSC, 8'h80);
    wr(OFS_BAUD, 8'h10);
    wr(OFS_TXSC, 8'hb4);
    repeat (4) @(posedge clk);
    cmp("clkIdle", 32'h1, {31'h0, txWire});
    d = rnd();
    wr(OFS_TXBUF, d);
    seen = 1'b0;
    for (int i = 0; i < 200 && !seen; i++) begin
      @(posedge clk);
      if (rxPinOe === 1'b1) seen = 1'b1;
    end
    cmp("dataDrive", 32'h1, {31'h0, seen});
    // data is steady mid-bit, where the clock leaves its high idle level
    for (int i = 0; i < 8; i++) begin
      @(negedge txWire);
      sd[i] = rxWire;
    end
    cmp("syncData", {24'h0, d}, {24'h0, sd});
    for (int i = 0; i < 2000 && rxPinOe === 1'b1; i++) @(posedge clk);
    repeat (40) @(posedge clk);
    cmp("clkIdle", 32'h1, {31'h0, txWire});
    wr(OFS_BAUD, 8'h00);
    repeat (4) @(posedge clk);
    cmp("clkIdle", 32'h0, {31'h0, txWire});
    repeat (4) @(posedge clk);
    giveVerdict();
  end
endmodule // sawb_tb_top
`default_nettype wire

// file: core/sawb_pkg.sv
// Purpose: constants and state type for the serial address/wake/break port
// Assumes: AHB-Lite register slave, one word per register
// Notes: all control state lives in one packed struct
package sawb_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [4:0] OFS_RXSC = 5'h00;
  localparam logic [4:0] OFS_RXBUF = 5'h04;
  localparam logic [4:0] OFS_TXSC = 5'h08;
  localparam logic [4:0] OFS_BAUD = 5'h0c;
  localparam logic [4:0] OFS_DIVH = 5'h10;
  localparam logic [4:0] OFS_DIVL = 5'h14;
  localparam logic [4:0] OFS_TXBUF = 5'h18;
  localparam logic [4:0] OFS_IRQ = 5'h1c;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int B_EN = 7;
  localparam int B_NINE = 6;
  localparam int B_SREN = 5;
  localparam int B_CONT = 4;
  localparam int B_ADDR = 3;
  localparam int B_TRANSMIT_ENABLE = 5;
  localparam int B_SYNC = 4;
  localparam int B_BRK = 3;
  localparam int B_POL = 4;
  localparam int B_WIDE = 3;
  localparam int B_WAKE = 1;
  // ----------------------------------------
  // bit timing and frames
  // ----------------------------------------
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SUB_MID = 4'h7;
  localparam logic [3:0] BRK_BITS = 4'he;
  localparam logic [13:0] BRK_FRAME = 14'h2000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sawb_rx_t;

  typedef struct packed {
    logic portEnable, nineBitRx, singleRx, contRx, addrDetect;
    logic frameErr, overrunErr, rxNinth;
    logic clkSrcSel, nineBitTx, txEnable, syncMode, sendBreak;
    logic highSpeed, txNinth, clkIdlePol, wideDiv, wakeEnable, wake;
    logic global_irq_enable, rie, rxFull, rxFlag, txFull;
    logic [7:0] divHigh, divLow, rxBuf, txBuf;
    logic [17:0] brgCnt;
    logic act, dirRx, brk;
    logic [13:0] sh;
    logic [3:0] sub, left;
    sawb_rx_t rxSt;
    logic [3:0] rsub, rbit;
    logic [8:0] rsh;
    logic s1, s2, s3;
    logic dph, dwr;
    logic [4:0] dadr;
    logic [31:0] rdata;
  } sawb_state_t;
endpackage

// file: core/sawb_top.sv
// Purpose: nine-bit address detect, wake on break, break send, sync master
// Assumes: rxPin is asynchronous; one 125 MHz clock
// Notes: register bus answers with zero wait states
//
// Operation
// - nine-bit words when nine-bit bit set; address detect when its enable set
// - receive flag set per word; interrupt needs receive and global enables
// - in sleep the baud generator stops and no byte is received
// - wake enable disables normal reception; port idles watching for wake
// - wake event is a falling edge on the receive line
// - wake event raises receive flag; reading receive buffer clears it
// - hardware clears wake enable at the following rising edge
// - break is a start bit, twelve zero bits, one stop bit
// - send break plus transmit enable sends a break; buffer data ignored
// - hardware clears send break after the break stop bit
// - wake mode tracks two edges, flags, then receives next byte normally
// - clock source bit selects master, sync bit selects sync mode
// - in sync mode transmit pin is clock, receive pin is data
// - sync master is half duplex
// - master drives clock; polarity bit selects idle high or low
// - async frames: start, eight or nine data lsb first, stop
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sawb_top
  import sawb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // system
  input wire logic sleepMode,
  output logic rxIrq,
  output logic txFlag,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial pins
  output logic txPinOut,
  output logic txPinOe,
  input wire logic rxPin,
  output logic rxPinOut,
  output logic rxPinOe
);
  import sawb_pkg::*;

  function automatic logic [3:0] wordBits(input logic nine);
    wordBits = nine ? 4'd9 : 4'd8;
  endfunction

  sawb_state_t q;
  sawb_state_t n;
  logic tick, fall, rise, syncM, acc, ldValid;
  logic [8:0] ldData;
  logic [15:0] lim;
  logic [17:0] reload;
  logic [31:0] rd;

  // ----------------------------------------
  // baud timing and edges
  // ----------------------------------------
  assign lim = q.wideDiv ? {q.divHigh, q.divLow} : {8'h00, q.divLow};
  // slow range divides by four more
  assign reload = (q.highSpeed | q.wideDiv) ? {2'b00, lim} : {lim, 2'b11};
  assign tick = (q.brgCnt == 18'h0) && !sleepMode;
  assign fall = q.s3 & ~q.s2;
  assign rise = ~q.s3 & q.s2;
  assign syncM = q.syncMode & q.clkSrcSel & q.portEnable;
  assign acc = hsel & htrans[1] & hready;

  always_comb begin
    rd = 32'h0;
    unique case (haddr[4:0])
      OFS_RXSC: rd[7:0] = {q.portEnable, q.nineBitRx, q.singleRx, q.contRx,
                           q.addrDetect, q.frameErr, q.overrunErr, q.rxNinth};
      OFS_RXBUF: rd[7:0] = q.rxBuf;
      OFS_TXSC: rd[7:0] = {q.clkSrcSel, q.nineBitTx, q.txEnable, q.syncMode,
                           q.sendBreak, q.highSpeed, ~q.act, q.txNinth};
      OFS_BAUD: rd[7:0] = {1'b0, q.rxSt == RX_IDLE, 1'b0, q.clkIdlePol,
                           q.wideDiv, 1'b0, q.wakeEnable, 1'b0};
      OFS_DIVH: rd[7:0] = q.divHigh;
      OFS_DIVL: rd[7:0] = q.divLow;
      OFS_IRQ: rd[7:0] = {4'h0, txFlag, q.rxFlag, q.rie, q.global_irq_enable};
      default: rd = 32'h0;
    endcase
  end

  always_comb begin
    n = q;
    ldValid = 1'b0;
    ldData = 9'h0;
    n.s1 = rxPin;
    n.s2 = q.s1;
    n.s3 = q.s2;
    if (tick) begin
      n.brgCnt = reload;
    end else if (!sleepMode) begin
      n.brgCnt = q.brgCnt - 18'h1;
    end
    // ----------------------------------------
    // bus data phase writes
    // ----------------------------------------
    n.dph = acc;
    if (acc) begin
      n.dwr = hwrite;
      n.dadr = haddr[4:0];
    end
    if (q.dph && q.dwr) begin
      unique case (q.dadr)
        OFS_RXSC: begin
          n.portEnable = hwdata[B_EN];
          n.nineBitRx = hwdata[B_NINE];
          n.singleRx = hwdata[B_SREN];
          n.contRx = hwdata[B_CONT];
          n.addrDetect = hwdata[B_ADDR];
          // dropping continuous receive clears the error flags
          if (!hwdata[B_CONT]) begin
            n.overrunErr = 1'b0;
            n.frameErr = 1'b0;
          end
        end
        OFS_TXSC: begin
          n.clkSrcSel = hwdata[7];
          n.nineBitTx = hwdata[6];
          n.txEnable = hwdata[B_TRANSMIT_ENABLE];
          n.syncMode = hwdata[B_SYNC];
          n.sendBreak = hwdata[B_BRK];
          n.highSpeed = hwdata[2];
          n.txNinth = hwdata[0];
        end
        OFS_BAUD: begin
          n.clkIdlePol = hwdata[B_POL];
          n.wideDiv = hwdata[B_WIDE];
          n.wakeEnable = hwdata[B_WAKE];
        end
        OFS_DIVH: n.divHigh = hwdata[7:0];
        OFS_DIVL: n.divLow = hwdata[7:0];
        OFS_TXBUF: begin
          n.txBuf = hwdata[7:0];
          n.txFull = 1'b1;
        end
        OFS_IRQ: begin
          n.global_irq_enable = hwdata[0];
          n.rie = hwdata[1];
        end
        default: n.dwr = 1'b0;
      endcase
    end
    // read side effect taken in the address phase; later sets still win
    if (acc && !hwrite) begin
      n.rdata = rd;
      if (haddr[4:0] == OFS_RXBUF) begin
        n.rxFlag = 1'b0;
        n.rxFull = 1'b0;
      end
    end
    // ----------------------------------------
    // shifter: async tx, sync tx and sync rx
    // ----------------------------------------
    if (!q.act) begin
      n.sub = 4'h0;
      if (q.txFull && q.txEnable && q.portEnable) begin
        // a write landing in this cycle refills the buffer, so its set wins
        n.txFull = q.dph && q.dwr && (q.dadr == OFS_TXBUF);
        n.act = 1'b1;
        n.dirRx = 1'b0;
        n.brk = q.sendBreak && !syncM;
        if (q.sendBreak && !syncM) begin
          n.sh = BRK_FRAME;
          n.left = BRK_BITS;
        end else if (syncM) begin
          n.sh = {5'h00, q.txNinth, q.txBuf};
          n.left = wordBits(q.nineBitTx);
        end else if (q.nineBitTx) begin
          n.sh = {4'hf, q.txNinth, q.txBuf, 1'b0};
          n.left = wordBits(1'b1) + 4'd2;
        end else begin
          n.sh = {5'h1f, q.txBuf, 1'b0};
          n.left = wordBits(1'b0) + 4'd2;
        end
      end else if (syncM && (q.contRx || q.singleRx)) begin
        // receive only while nothing waits to go out
        n.act = 1'b1;
        n.dirRx = 1'b1;
        n.brk = 1'b0;
        n.sh = 14'h0;
        n.left = wordBits(q.nineBitRx);
      end
    end else if (tick) begin
      n.sub = q.sub + 4'h1;
      if (q.sub == SUB_LAST) begin
        n.sh = {q.dirRx ? q.s2 : 1'b1, q.sh[13:1]};
        n.left = q.left - 4'h1;
        if (q.left == 4'h1) begin
          n.act = 1'b0;
          if (q.brk) begin
            n.sendBreak = 1'b0;
          end
          if (q.dirRx) begin
            ldValid = 1'b1;
            ldData = q.nineBitRx ? n.sh[13:5] : {1'b0, n.sh[13:6]};
            if (!q.contRx) begin
              n.singleRx = 1'b0;
            end
          end
        end
      end
    end
    // ----------------------------------------
    // async receiver
    // ----------------------------------------
    if (!(q.portEnable && q.contRx && !q.syncMode && !q.wakeEnable && !sleepMode)) begin
      n.rxSt = RX_IDLE;
    end else begin
      if (tick) begin
        n.rsub = q.rsub + 4'h1;
      end
      unique case (q.rxSt)
        RX_IDLE: if (fall) begin
          n.rxSt = RX_START;
          n.rsub = 4'h0;
        end
        RX_START: if (tick && q.rsub == SUB_MID) begin
          n.rxSt = q.s2 ? RX_IDLE : RX_DATA;
          n.rsub = 4'h0;
          n.rbit = 4'h0;
        end
        RX_DATA: if (tick && q.rsub == SUB_LAST) begin
          n.rsh = {q.s2, q.rsh[8:1]};
          n.rbit = q.rbit + 4'h1;
          if (q.rbit == wordBits(q.nineBitRx) - 4'h1) begin
            n.rxSt = RX_STOP;
          end
        end
        RX_STOP: if (tick && q.rsub == SUB_LAST) begin
          n.rxSt = RX_IDLE;
          n.frameErr = !q.s2;
          ldValid = 1'b1;
          ldData = q.nineBitRx ? q.rsh : {1'b0, q.rsh[8:1]};
        end
      endcase
    end
    // ----------------------------------------
    // buffer load and wake
    // ----------------------------------------
    if (ldValid) begin
      if (q.addrDetect && q.nineBitRx && !ldData[8]) begin
        n.rxSt = RX_IDLE;
      end else if (q.rxFull) begin
        n.overrunErr = 1'b1;
      end else begin
        n.rxBuf = ldData[7:0];
        n.rxNinth = ldData[8];
        n.rxFull = 1'b1;
        n.rxFlag = 1'b1;
      end
    end
    if (q.wakeEnable) begin
      if (fall) begin
        n.rxFlag = 1'b1;
        n.wake = 1'b1;
      end else if (rise && q.wake) begin
        n.wakeEnable = 1'b0;
        n.wake = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rxIrq = q.rxFlag & q.rie & q.global_irq_enable;
  assign txFlag = q.txEnable & ~q.txFull;
  assign hrdata = q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // clock out toggles only during a word, so idle level is the polarity bit
  assign txPinOut = syncM ? (q.clkIdlePol ^ (q.act & q.sub[3])) :
                    ((q.act & ~q.dirRx) ? q.sh[0] : 1'b1);
  assign txPinOe = q.portEnable;
  assign rxPinOut = q.sh[0];
  assign rxPinOe = syncM & q.act & ~q.dirRx;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_addr_filter;
    @(posedge clk) disable iff (rst)
    ldValid && q.addrDetect && q.nineBitRx && !ldData[8] |=> !$rose(q.rxFull);
  endproperty
  a_addr_filter: assert property (p_addr_filter) else $error("address filter leak");

  property p_irq;
    @(posedge clk) disable iff (rst)
    $rose(q.rxFlag) && q.rie && q.global_irq_enable |-> rxIrq ##1 (rxIrq == (q.rxFlag && q.rie && q.global_irq_enable));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_sleep;
    @(posedge clk) disable iff (rst)
    sleepMode |-> !tick ##1 (q.rxSt == RX_IDLE);
  endproperty
  a_sleep: assert property (p_sleep) else $error("activity in sleep");

  property p_wake_idle;
    @(posedge clk) disable iff (rst)
    q.wakeEnable |=> q.rxSt == RX_IDLE;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("rx ran in wake mode");

  property p_wake_flag;
    @(posedge clk) disable iff (rst)
    q.wakeEnable && fall |=> q.rxFlag && q.wake;
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake flag missing");

  property p_wake_clear;
    @(posedge clk) disable iff (rst)
    q.wakeEnable && q.wake && rise && !fall |=> !q.wakeEnable;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake not cleared");

  property p_brk_load;
    @(posedge clk) disable iff (rst)
    !q.act && q.txFull && q.txEnable && q.portEnable && q.sendBreak && !syncM
      |=> q.sh == BRK_FRAME && q.left == BRK_BITS && q.brk;
  endproperty
  a_brk_load: assert property (p_brk_load) else $error("bad break frame");

  property p_brk_clear;
    @(posedge clk) disable iff (rst)
    q.act && q.brk && tick && q.sub == SUB_LAST && q.left == 4'h1 |=> !q.sendBreak;
  endproperty
  a_brk_clear: assert property (p_brk_clear) else $error("send break stuck");

  property p_clk_idle;
    @(posedge clk) disable iff (rst)
    syncM && !q.act |-> txPinOut == q.clkIdlePol && !rxPinOe;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("clock idle level");

  property p_half_duplex;
    @(posedge clk) disable iff (rst)
    syncM && !q.act && q.txFull && q.txEnable |=> q.act && !q.dirRx;
  endproperty
  a_half_duplex: assert property (p_half_duplex) else $error("rx took a pending word slot");

  c_break: cover property (@(posedge clk) disable iff (rst) $fell(q.sendBreak));
  c_wake: cover property (@(posedge clk) disable iff (rst) $fell(q.wakeEnable));
  c_load: cover property (@(posedge clk) disable iff (rst) $rose(q.rxFull) && q.addrDetect);
  c_sync: cover property (@(posedge clk) disable iff (rst) syncM && q.act && q.dirRx);
endmodule // sawb_top
`default_nettype wire
